// ===== core/fcc_pkg.sv
// Constants and carrier types of the flash command controller
package fcc_pkg;
	localparam int          DATA_W      = 16;
	localparam int          ADDR_W      = 18;
	localparam int          REG_ADDR_W  = 4;
	// Register offsets
	localparam logic [3:0]  OFS_CLKDIV  = 4'h0;
	localparam logic [3:0]  OFS_PARIDX  = 4'h1;
	localparam logic [3:0]  OFS_CFG     = 4'h2;
	localparam logic [3:0]  OFS_ERRCFG  = 4'h3;
	localparam logic [3:0]  OFS_STAT    = 4'h4;
	localparam logic [3:0]  OFS_ERRSTAT = 4'h5;
	localparam logic [3:0]  OFS_PARAM   = 4'h6;
	// Field positions
	localparam int          DIV_LOADED_BIT = 7;
	localparam int          DIV_LOCKED_BIT = 6;
	localparam int          COMMAND_COMPLETE_IRQ_ENABLE_BIT       = 7;
	localparam int          DOUBLE_FAULT_IRQ_ENABLE_BIT      = 1;
	localparam int          SINGLE_FAULT_IRQ_ENABLE_BIT      = 0;
	localparam int          CCF_BIT        = 7;
	localparam int          ACCESS_ERROR_FLAG_BIT     = 5;
	localparam int          PVIOL_BIT      = 4;
	localparam int          BUSY_BIT       = 3;
	localparam int          VHI_BIT        = 1;
	localparam int          VLO_BIT        = 0;
	localparam int          DFLAG_BIT      = 1;
	localparam int          SFLAG_BIT      = 0;
	// Reset values
	localparam logic [5:0]  DIV_RESET   = 6'h00;
	localparam logic [7:0]  CMD_RESET   = 8'h00;
	// Command codes and parameter indices
	localparam logic [7:0]  CMD_EVB     = 8'h02;
	localparam logic [7:0]  CMD_EVS     = 8'h03;
	localparam logic [7:0]  CMD_PGM     = 8'h06;
	localparam logic [2:0]  IDX_EVB     = 3'h0;
	localparam logic [2:0]  IDX_EVS     = 3'h2;
	localparam logic [2:0]  IDX_PGM     = 3'h5;
	localparam int          NUM_PARAMS  = 6;
	localparam logic [1:0]  SEL_EEPROM  = 2'h0;
	localparam logic [1:0]  SEL_PFLASH  = 2'h3;
	localparam logic [15:0] ERASED_WORD = 16'hFFFF;
	// Timing: program pulse per word, in divided 1 MHz ticks
	localparam int          PGM_WORD_US   = 20;
	localparam int          TICK_PER_US   = 1;
	localparam logic [7:0]  PGM_WORD_TICKS = 8'(PGM_WORD_US * TICK_PER_US);

	typedef enum logic [2:0] {FCC_IDLE, FCC_VREAD, FCC_VWAIT, FCC_VCHECK, FCC_PWRITE, FCC_PWAIT} fcc_state_t;

	typedef struct packed {
		logic              rd;
		logic              wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} fcc_arr_req_t;

	typedef struct packed {
		logic [DATA_W-1:0] rdata;
		logic              singleErr;
		logic              doubleErr;
	} fcc_arr_rsp_t;
endpackage

// ===== core/fcc_flash_ctrl.sv
// Flash command sequencer with register port and array interface
//
// Overview of operation
// - Code 0x02 at index 000 launches block verify
// - Select 00 EEPROM, 11 program flash, else error
// - Check whole block, then set completion flag
// - Non-erased location sets both verify bits
// - Block verify needs index 000 at launch
// - Invalid select code raises access error
// - No protection flag; verify bits from reads
// - Section verify checks address and phrase range
// - Command interrupt from completion flag and enable
// - Error interrupt from enabled fault flags
// - First divider write sets loaded bit
// - Lock bit freezes divide field until reset
// - Divide field makes 1 MHz program tick
// - Program phrase, read back, then complete
// - Program needs index 101 at launch
// - Program address must be phrase aligned
// - Program needs permitted mode, valid address
// - Protected target sets violation, no program
// - Read-back errors set verify bits
// - Writing one clears flag and launches
`timescale 1ns/1ns
`default_nettype none
module fcc_flash_ctrl
	import fcc_pkg::*;
#(
	parameter logic [17:0] PF_BASE  = 18'h20000,
	parameter int          PF_BYTES = 65536,
	parameter logic [17:0] EE_BASE  = 18'h00400,
	parameter int          EE_BYTES = 1024
) (
	input  wire logic                  clk,
	input  wire logic                  rstn,
	input  wire logic [REG_ADDR_W-1:0] regAddr,
	input  wire logic [DATA_W-1:0]     regWdata,
	input  wire logic                  regWe,
	input  wire logic                  regRe,
	output logic      [DATA_W-1:0]     regRdata,
	input  wire logic                  progEnable,
	input  wire logic [ADDR_W-1:0]     protBase,
	output fcc_arr_req_t               arrReq,
	input  wire fcc_arr_rsp_t          arrRsp,
	output logic                       cmdIrq,
	output logic                       errIrq
);
	function automatic logic inRange(input logic [19:0] a, input logic [19:0] lo, input logic [19:0] len);
		inRange = (a >= lo) && (a < lo + len);
	endfunction

	logic [1:0]        rstSync_q;
	logic              rstnInt;
	logic [5:0]        div_q;
	logic              divLoaded_q, divLocked_q;
	logic [5:0]        tickCnt_q;
	logic              tick;
	logic [2:0]        parIdx_q;
	logic [15:0]       param_q [NUM_PARAMS];
	logic              command_complete_irq_enable_q, double_fault_irq_enable_q, single_fault_irq_enable_q;
	logic              ccf_q, access_error_flag_q, pViol_q, vHi_q, vLo_q;
	logic              dFlag_q, sFlag_q;
	fcc_state_t        state_q;
	logic              isPgm_q;
	logic [19:0]       curAddr_q, startAddr_q, endAddr_q;
	logic [1:0]        wordIdx_q;
	logic [7:0]        waitCnt_q;
	fcc_arr_req_t      arrReq_q;
	logic [DATA_W-1:0] rdata_q;
	logic              cmdIrq_q, errIrq_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rstSync_q <= 2'h0;
		end else begin
			rstSync_q <= {rstSync_q[0], 1'b1};
		end
	end
	assign rstnInt = rstSync_q[1];

	// Register decode
	wire wrDiv    = regWe && regAddr == OFS_CLKDIV;
	wire wrIdx    = regWe && regAddr == OFS_PARIDX;
	wire wrCfg    = regWe && regAddr == OFS_CFG;
	wire wrErrCfg = regWe && regAddr == OFS_ERRCFG;
	wire wrStat   = regWe && regAddr == OFS_STAT;
	wire wrErrSt  = regWe && regAddr == OFS_ERRSTAT;
	// Parameters frozen mid-command so the sequencer sees stable data
	wire wrParam  = regWe && regAddr == OFS_PARAM && ccf_q && parIdx_q < 3'(NUM_PARAMS);
	wire launch   = wrStat && regWdata[CCF_BIT] && ccf_q;

	// Command decode
	wire [7:0]  cmdCode = param_q[0][15:8];
	wire [1:0]  selCode = param_q[0][1:0];
	wire [19:0] gAddr   = {2'h0, param_q[0][1:0], param_q[1]};
	wire [19:0] secEnd  = gAddr + {1'b0, param_q[2], 3'h0};
	wire        aligned = gAddr[2:0] == 3'h0;
	wire        addrPf  = inRange(gAddr, {2'h0, PF_BASE}, 20'(PF_BYTES));
	wire        selOk   = selCode == SEL_EEPROM || selCode == SEL_PFLASH;
	wire        errEvb  = parIdx_q != IDX_EVB || !selOk;
	wire        errEvs  = parIdx_q != IDX_EVS || !aligned || !addrPf || param_q[2] == 16'h0000
	                      || secEnd > {2'h0, PF_BASE} + 20'(PF_BYTES);
	wire        errPgm  = parIdx_q != IDX_PGM || !aligned || !addrPf || !progEnable;
	wire        cmdErr  = !divLoaded_q || (cmdCode == CMD_EVB ? errEvb :
	                      cmdCode == CMD_EVS ? errEvs : cmdCode == CMD_PGM ? errPgm : 1'b1);
	wire        protHit = cmdCode == CMD_PGM && !cmdErr && gAddr[17:0] >= protBase;
	wire        goOn    = launch && !cmdErr && !protHit;
	wire [19:0] blkBase = selCode == SEL_EEPROM ? {2'h0, EE_BASE} : {2'h0, PF_BASE};
	wire [19:0] blkLen  = selCode == SEL_EEPROM ? 20'(EE_BYTES) : 20'(PF_BYTES);

	// Verify step
	wire        check    = state_q == FCC_VCHECK;
	wire [15:0] expect_w = isPgm_q ? param_q[2 + int'(wordIdx_q)] : ERASED_WORD;
	wire        mismatch = arrRsp.rdata != expect_w;
	wire        lastWord = curAddr_q + 20'h2 >= endAddr_q;
	wire        setDbl   = check && arrRsp.doubleErr;
	wire        setSgl   = check && arrRsp.singleErr && !arrRsp.doubleErr;
	wire        setHi    = check && (arrRsp.doubleErr || arrRsp.singleErr || mismatch);
	wire        setLo    = check && (arrRsp.doubleErr || mismatch);
	wire        done     = check && lastWord;

	// Divided 1 MHz tick
	// Free-running, so a word's first tick may come early
	assign tick = tickCnt_q == div_q;
	always_ff @(posedge clk or negedge rstnInt) begin
		if (!rstnInt) begin
			tickCnt_q <= 6'h00;
		end else begin
			tickCnt_q <= tick ? 6'h00 : tickCnt_q + 6'h01;
		end
	end

	// Divider register; lock freezes the field, only reset reopens it
	always_ff @(posedge clk or negedge rstnInt) begin
		if (!rstnInt) begin
			div_q       <= DIV_RESET;
			divLoaded_q <= 1'b0;
			divLocked_q <= 1'b0;
		end else if (wrDiv) begin
			divLoaded_q <= 1'b1;
			divLocked_q <= divLocked_q | regWdata[DIV_LOCKED_BIT];
			if (!divLocked_q) begin
				div_q <= regWdata[5:0];
			end
		end
	end

	// Configuration and parameter registers
	always_ff @(posedge clk or negedge rstnInt) begin
		if (!rstnInt) begin
			parIdx_q <= 3'h0;
			command_complete_irq_enable_q   <= 1'b0;
			double_fault_irq_enable_q  <= 1'b0;
			single_fault_irq_enable_q  <= 1'b0;
		end else begin
			if (wrIdx && ccf_q) begin
				parIdx_q <= regWdata[2:0];
			end
			if (wrCfg) begin
				command_complete_irq_enable_q <= regWdata[COMMAND_COMPLETE_IRQ_ENABLE_BIT];
			end
			if (wrErrCfg) begin
				double_fault_irq_enable_q <= regWdata[DOUBLE_FAULT_IRQ_ENABLE_BIT];
				single_fault_irq_enable_q <= regWdata[SINGLE_FAULT_IRQ_ENABLE_BIT];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (wrParam) begin
			param_q[parIdx_q] <= regWdata;
		end
	end

	// Status flags; hardware set wins over software clear
	always_ff @(posedge clk or negedge rstnInt) begin
		if (!rstnInt) begin
			ccf_q    <= 1'b1;
			access_error_flag_q <= 1'b0;
			pViol_q  <= 1'b0;
			vHi_q    <= 1'b0;
			vLo_q    <= 1'b0;
			dFlag_q  <= 1'b0;
			sFlag_q  <= 1'b0;
		end else begin
			if (launch) begin
				ccf_q    <= !goOn;
				access_error_flag_q <= cmdErr;
				pViol_q  <= protHit;
				vHi_q    <= 1'b0;
				vLo_q    <= 1'b0;
			end else begin
				if (done) begin
					ccf_q <= 1'b1;
				end
				if (wrStat && regWdata[ACCESS_ERROR_FLAG_BIT]) begin
					access_error_flag_q <= 1'b0;
				end
				if (wrStat && regWdata[PVIOL_BIT]) begin
					pViol_q <= 1'b0;
				end
				vHi_q <= vHi_q | setHi;
				vLo_q <= vLo_q | setLo;
			end
			dFlag_q <= setDbl | (dFlag_q & !(wrErrSt && regWdata[DFLAG_BIT]));
			sFlag_q <= setSgl | (sFlag_q & !(wrErrSt && regWdata[SFLAG_BIT]));
		end
	end

	// Sequencer
	always_ff @(posedge clk or negedge rstnInt) begin
		if (!rstnInt) begin
			state_q     <= FCC_IDLE;
			isPgm_q     <= 1'b0;
			curAddr_q   <= 20'h0;
			startAddr_q <= 20'h0;
			endAddr_q   <= 20'h0;
			wordIdx_q   <= 2'h0;
			waitCnt_q   <= 8'h00;
		end else begin
			case (state_q)
				FCC_IDLE: begin
					if (goOn) begin
						isPgm_q   <= cmdCode == CMD_PGM;
						wordIdx_q <= 2'h0;
						if (cmdCode == CMD_EVB) begin
							curAddr_q <= blkBase;
							endAddr_q <= blkBase + blkLen;
							state_q   <= FCC_VREAD;
						end else if (cmdCode == CMD_EVS) begin
							curAddr_q <= gAddr;
							endAddr_q <= secEnd;
							state_q   <= FCC_VREAD;
						end else begin
							curAddr_q   <= gAddr;
							startAddr_q <= gAddr;
							endAddr_q   <= gAddr + 20'h8;
							state_q     <= FCC_PWRITE;
						end
					end
				end
				FCC_VREAD: state_q <= FCC_VWAIT;
				FCC_VWAIT: state_q <= FCC_VCHECK;
				FCC_VCHECK: begin
					curAddr_q <= curAddr_q + 20'h2;
					wordIdx_q <= wordIdx_q + 2'h1;
					state_q   <= lastWord ? FCC_IDLE : FCC_VREAD;
				end
				FCC_PWRITE: begin
					waitCnt_q <= PGM_WORD_TICKS;
					state_q   <= FCC_PWAIT;
				end
				FCC_PWAIT: begin
					if (tick) begin
						waitCnt_q <= waitCnt_q - 8'h01;
					end
					if (tick && waitCnt_q == 8'h01) begin
						wordIdx_q <= wordIdx_q + 2'h1;
						// Word index wraps to zero, so read-back starts at word 0
						if (curAddr_q + 20'h2 >= endAddr_q) begin
							curAddr_q <= startAddr_q;
							state_q   <= FCC_VREAD;
						end else begin
							curAddr_q <= curAddr_q + 20'h2;
							state_q   <= FCC_PWRITE;
						end
					end
				end
				default: state_q <= FCC_IDLE;
			endcase
		end
	end

	// Array strobes, read data and interrupt requests, all registered
	wire [15:0] statRd = 16'({ccf_q, 1'b0, access_error_flag_q, pViol_q, state_q != FCC_IDLE, 1'b0, vHi_q, vLo_q});
	wire [15:0] rdMux  = regAddr == OFS_CLKDIV  ? 16'({divLoaded_q, divLocked_q, div_q}) :
	                     regAddr == OFS_PARIDX  ? 16'(parIdx_q) :
	                     regAddr == OFS_CFG     ? 16'({command_complete_irq_enable_q, 7'h00}) :
	                     regAddr == OFS_ERRCFG  ? 16'({double_fault_irq_enable_q, single_fault_irq_enable_q}) :
	                     regAddr == OFS_STAT    ? statRd :
	                     regAddr == OFS_ERRSTAT ? 16'({dFlag_q, sFlag_q}) :
	                     regAddr == OFS_PARAM && parIdx_q < 3'(NUM_PARAMS) ? param_q[parIdx_q] : 16'h0000;

	always_ff @(posedge clk or negedge rstnInt) begin
		if (!rstnInt) begin
			arrReq_q <= '0;
			rdata_q  <= 16'h0000;
			cmdIrq_q <= 1'b0;
			errIrq_q <= 1'b0;
		end else begin
			arrReq_q.rd    <= state_q == FCC_VREAD;
			arrReq_q.wr    <= state_q == FCC_PWRITE;
			arrReq_q.addr  <= curAddr_q[17:0];
			arrReq_q.wdata <= param_q[2 + int'(wordIdx_q)];
			rdata_q        <= regRe ? rdMux : 16'h0000;
			cmdIrq_q       <= ccf_q && command_complete_irq_enable_q;
			errIrq_q       <= (dFlag_q && double_fault_irq_enable_q) || (sFlag_q && single_fault_irq_enable_q);
		end
	end

	assign arrReq   = arrReq_q;
	assign regRdata = rdata_q;
	assign cmdIrq   = cmdIrq_q;
	assign errIrq   = errIrq_q;

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstnInt);

	launch_clear_a: assert property (goOn |=> !ccf_q && state_q != FCC_IDLE)
		else $error("launch did not clear completion flag");
	refuse_flag_a: assert property (launch && cmdErr |=> ccf_q && access_error_flag_q && state_q == FCC_IDLE)
		else $error("refused launch not reported");
	bad_select_a: assert property (launch && cmdCode == CMD_EVB && !selOk |=> access_error_flag_q)
		else $error("invalid select not flagged");
	evb_no_prot_a: assert property (launch && cmdCode == CMD_EVB |=> !pViol_q)
		else $error("block verify set protection flag");
	blank_fail_a: assert property (check && !isPgm_q && mismatch && !launch |=> vHi_q && vLo_q)
		else $error("blank failure missed verify bits");
	done_flag_a: assert property (done |=> ccf_q && state_q == FCC_IDLE)
		else $error("completion flag not set");
	prot_hold_a: assert property (launch && protHit |=> ccf_q && pViol_q ##1 !arrReq.wr)
		else $error("protected program went on");
	lock_keep_a: assert property (divLocked_q && wrDiv |=> $stable(div_q))
		else $error("locked divider changed");
	loaded_bit_a: assert property (wrDiv |=> divLoaded_q)
		else $error("divider loaded bit not set");
	cmd_irq_a: assert property (ccf_q && command_complete_irq_enable_q |=> cmdIrq)
		else $error("command interrupt missing");
	err_irq_a: assert property (dFlag_q && double_fault_irq_enable_q |=> errIrq)
		else $error("error interrupt missing");
	pgm_idx_a: assert property (launch && cmdCode == CMD_PGM && parIdx_q != IDX_PGM |=> access_error_flag_q)
		else $error("program index not checked");
	// Launch refusals
	evb_index_a: assert property (launch && cmdCode == CMD_EVB && parIdx_q != IDX_EVB |=> access_error_flag_q && ccf_q)
		else $error("block verify index not checked");
	pgm_align_a: assert property (launch && cmdCode == CMD_PGM && gAddr[2:0] != 3'h0 |=> access_error_flag_q)
		else $error("misaligned program not refused");
	pgm_mode_a: assert property (launch && cmdCode == CMD_PGM && !progEnable |=> access_error_flag_q)
		else $error("program in wrong mode not refused");
	pgm_range_a: assert property (launch && cmdCode == CMD_PGM && !addrPf |=> access_error_flag_q)
		else $error("program outside flash not refused");
	evs_range_a: assert property (launch && cmdCode == CMD_EVS && param_q[2] == 16'h0000 |=> access_error_flag_q)
		else $error("empty section not refused");
	// Block selection picks the array window
	ee_select_a: assert property (goOn && cmdCode == CMD_EVB && selCode == SEL_EEPROM
		|=> curAddr_q == 20'(EE_BASE))
		else $error("eeprom block not selected");
	pf_select_a: assert property (goOn && cmdCode == CMD_EVB && selCode == SEL_PFLASH
		|=> curAddr_q == 20'(PF_BASE))
		else $error("program flash block not selected");
	// Program sequence, read-back and single fault interrupt
	pgm_wait_a: assert property (state_q == FCC_PWAIT && !tick |=> $stable(waitCnt_q))
		else $error("pulse count moved without tick");
	pgm_verify_a: assert property (state_q == FCC_PWAIT && tick && waitCnt_q == 8'h01 && lastWord
		|=> state_q == FCC_VREAD && !ccf_q)
		else $error("program skipped read-back");
	pgm_busy_a: assert property (arrReq.wr |-> !ccf_q)
		else $error("flag high while programming");
	busy_low_a: assert property (state_q != FCC_IDLE |-> !ccf_q)
		else $error("flag high while busy");
	readback_hi_a: assert property (check && isPgm_q
		&& (mismatch || arrRsp.singleErr || arrRsp.doubleErr) |=> vHi_q)
		else $error("read-back error missed high bit");
	readback_lo_a: assert property (check && isPgm_q && arrRsp.doubleErr |=> vLo_q)
		else $error("read-back fault missed low bit");
	sgl_fault_a: assert property (sFlag_q && single_fault_irq_enable_q |=> errIrq)
		else $error("single fault interrupt missing");

	evb_run_c: cover property (goOn && cmdCode == CMD_EVB ##[1:1000] done);
	evs_run_c: cover property (goOn && cmdCode == CMD_EVS ##[1:1000] done);
	pgm_run_c: cover property (goOn && cmdCode == CMD_PGM ##[1:1000] done);
	prot_hit_c: cover property (launch && protHit);
	fault_c: cover property (setDbl);
endmodule
`default_nettype wire

// ===== dv/fcc_flash_ctrl_tb.sv
// Self-checking testbench of the flash command controller
`timescale 1ns/1ns
`default_nettype none
module testbench import fcc_pkg::*;;
	localparam logic [17:0] PFB = 18'h20000;
	localparam logic [17:0] EEB = 18'h00400;
	logic              clk, rstn, regWe, regRe, progEnable, cmdIrq, errIrq, eccS, eccD;
	logic [3:0]        regAddr;
	logic [15:0]       regWdata, regRdata, s;
	logic [17:0]       protBase;
	fcc_arr_req_t      arrReq;
	fcc_arr_rsp_t      arrRsp = '0;
	logic [15:0]       mem [int];
	int                numErrors, nChecks, n;

	// Small blocks keep the whole-block verify short
	fcc_flash_ctrl #(.PF_BASE(PFB), .PF_BYTES(64), .EE_BASE(EEB), .EE_BYTES(32)) dut_u (
		.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWe(regWe),
		.regRe(regRe), .regRdata(regRdata), .progEnable(progEnable), .protBase(protBase),
		.arrReq(arrReq), .arrRsp(arrRsp), .cmdIrq(cmdIrq), .errIrq(errIrq));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	function automatic logic [15:0] rdm(input logic [17:0] a);
		return mem.exists(int'(a)) ? mem[int'(a)] : ERASED_WORD;
	endfunction

	// Array answers in the cycle after a read; otherwise data toggles so stale values never match
	always @(posedge clk) begin
		if (arrReq.wr)
			mem[int'(arrReq.addr)] = arrReq.wdata;
		if (arrReq.rd)
			arrRsp <= '{rdata: rdm(arrReq.addr), singleErr: eccS, doubleErr: eccD};
		else
			arrRsp <= '{rdata: ~arrRsp.rdata, singleErr: 1'b0, doubleErr: 1'b0};
	end

	task automatic stopTest();
		$display("checks %0d mismatches %0d", nChecks, numErrors);
		if (numErrors == 0 && nChecks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
		nChecks++;
		if (seen !== exp) begin
			numErrors++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		regWe <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk);
		regWe <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		regRe <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRe <= 1'b0;
		#1 d = regRdata;
	endtask

	task automatic setp(input logic [2:0] ix, input logic [15:0] v);
		wr(OFS_PARIDX, {13'h0, ix});
		wr(OFS_PARAM, v);
	endtask

	// Polls until complete; n counts clock cycles spent
	task automatic run();
		wr(OFS_STAT, 16'h0080);
		for (n = 0; n < 6000; n += 2) begin
			rd(OFS_STAT, s);
			if (s[CCF_BIT] === 1'b1)
				return;
		end
		chk(s, 16'h0080, "command never completed");
		stopTest();
	endtask

	task automatic evb(input logic [1:0] sel, input logic [2:0] ix);
		setp(3'h0, {CMD_EVB, 6'h00, sel});
		if (ix != 3'h0)
			wr(OFS_PARIDX, {13'h0, ix});
		run();
	endtask

	task automatic pg(input logic [17:0] a, input logic [2:0] ix);
		setp(3'h0, {CMD_PGM, 6'h00, a[17:16]});
		setp(3'h1, a[15:0]);
		for (int k = 2; k < 6; k++)
			setp(3'(k), 16'hA5A0 + 16'(k));
		wr(OFS_PARIDX, {13'h0, ix});
		run();
	endtask

	task automatic evs(input logic [17:0] a, input logic [15:0] cnt);
		setp(3'h0, {CMD_EVS, 6'h00, a[17:16]});
		setp(3'h1, a[15:0]);
		setp(3'h2, cnt);
		run();
	endtask

	task automatic tRegs();
		rd(OFS_CLKDIV, s); chk(s, 16'h0000, "divider after reset");
		rd(OFS_STAT, s); chk(s, 16'h0080, "status after reset");
		rd(4'hF, s); chk(s, 16'h0000, "unmapped read");
		evb(SEL_EEPROM, 3'h0); chk(s, 16'h00A0, "launch without divider");
		wr(OFS_CLKDIV, 16'h0009);
		rd(OFS_CLKDIV, s); chk(s, 16'h0089, "divider loaded");
		wr(OFS_CLKDIV, 16'h0049);
		wr(OFS_CLKDIV, 16'h0005);
		rd(OFS_CLKDIV, s); chk(s, 16'h00C9, "divider locked");
		$display("test regs done");
	endtask

	task automatic tBlock();
		for (int k = 0; k < 4; k++) begin
			evb(2'(k), 3'h0); chk(s, (k == 0 || k == 3) ? 16'h0080 : 16'h00A0, "block select");
		end
		evb(SEL_PFLASH, 3'h1); chk(s, 16'h00A0, "wrong index");
		wr(OFS_CFG, 16'h0080);
		mem[int'(EEB + 18'h6)] = 16'h1234;
		setp(3'h0, {CMD_EVB, 6'h00, SEL_EEPROM});
		wr(OFS_STAT, 16'h0080);
		rd(OFS_STAT, s); chk(s & 16'h0088, 16'h0008, "flag low while busy");
		chk({15'h0, cmdIrq}, 16'h0000, "irq while busy");
		run(); chk(s, 16'h0083, "blank check failed");
		chk({15'h0, cmdIrq}, 16'h0001, "irq on completion");
		mem.delete(int'(EEB + 18'h6));
		wr(OFS_ERRCFG, 16'h0001);
		@(posedge clk) eccS <= 1'b1;
		evb(SEL_PFLASH, 3'h0); chk(s, 16'h0082, "single fault verify");
		@(posedge clk) eccS <= 1'b0;
		rd(OFS_ERRSTAT, s); chk(s, 16'h0001, "single fault flag");
		chk({15'h0, errIrq}, 16'h0001, "single fault irq");
		wr(OFS_ERRSTAT, 16'h0001);
		rd(OFS_ERRSTAT, s); chk(16'({s[1:0], errIrq}), 16'h0000, "fault cleared");
		wr(OFS_ERRCFG, 16'h0002);
		@(posedge clk) eccD <= 1'b1;
		evb(SEL_PFLASH, 3'h0); chk(s, 16'h0083, "double fault verify");
		@(posedge clk) eccD <= 1'b0;
		rd(OFS_ERRSTAT, s); chk(16'({s[1:0], errIrq}), 16'h0005, "double fault flag and irq");
		wr(OFS_ERRSTAT, 16'h0003);
		$display("test block verify done");
	endtask

	task automatic tProg();
		pg(PFB, 3'h5); chk(s, 16'h0080, "program ok");
		chk(16'(n >= 4 * PGM_WORD_TICKS * 10 && n <= 4 * (PGM_WORD_TICKS + 1) * 10), 16'h0001, "pulse timing");
		for (int k = 0; k < 4; k++)
			chk(rdm(PFB + 18'(2 * k)), 16'hA5A2 + 16'(k), "programmed word");
		pg(PFB, 3'h4); chk(s, 16'h00A0, "program index");
		pg(PFB + 18'h4, 3'h5); chk(s, 16'h00A0, "misaligned");
		pg(PFB + 18'h40, 3'h5); chk(s, 16'h00A0, "outside flash");
		@(posedge clk) progEnable <= 1'b0;
		pg(PFB + 18'h8, 3'h5); chk(s, 16'h00A0, "mode forbids");
		@(posedge clk) progEnable <= 1'b1;
		pg(PFB + 18'h20, 3'h5); chk(s, 16'h0090, "protected");
		chk(rdm(PFB + 18'h20), ERASED_WORD, "protected untouched");
		@(posedge clk) eccD <= 1'b1;
		pg(PFB + 18'h8, 3'h5); chk(s, 16'h0083, "read-back fault");
		@(posedge clk) eccD <= 1'b0;
		wr(OFS_ERRSTAT, 16'h0003);
		evs(PFB + 18'h10, 16'h0002); chk(s, 16'h0080, "section erased");
		evs(PFB + 18'h8, 16'h0001); chk(s, 16'h0083, "section dirty");
		evs(PFB, 16'h0000); chk(s, 16'h00A0, "zero count");
		$display("test program done");
	endtask

	initial begin
		rstn = 1'b0;
		regWe = 1'b0;
		regRe = 1'b0;
		regAddr = 4'h0;
		regWdata = 16'h0000;
		progEnable = 1'b1;
		protBase = PFB + 18'h20;
		eccS = 1'b0;
		eccD = 1'b0;
		numErrors = 0;
		nChecks = 0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		tRegs();
		tBlock();
		tProg();
		stopTest();
	end
endmodule
`default_nettype wire
